// ---- rtl/hbp_host.sv ----
// host end: drives bus cycles and keeps the device's pacing gaps
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus pins
  hbp_bus_if.host bus,
  // configuration
  input wire logic slow_arbitration,
  input wire logic relaxed_timing,
  input wire logic mux_bus,
  input wire logic strobe_style,
  input wire logic double_cycle,
  input wire logic bus_timing_high,
  // request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);

  typedef enum {H_IDLE, H_ALE, H_ALE_LOW, H_SETUP, H_STROBE, H_HOLD} hbp_hstate_e;

  typedef struct packed {
    hbp_hstate_e state;
    hbp_pkg::hbp_cnt_t cnt;
    hbp_pkg::hbp_cnt_t lead_cnt;
    hbp_pkg::hbp_cnt_t trail_cnt;
    hbp_pkg::hbp_kind_e prev_kind;
    logic write;
    logic [2:0] addr;
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ds_n;
    logic dir;
    logic bt;
    logic d_oe_n;
    logic [7:0] wdata;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] dfilt;
    logic rsp_valid;
    logic [7:0] rdata;
  } hbp_host_s;

  hbp_host_s r, n;
  logic [7:0] scale;
  logic [7:0] low_cyc;
  logic [7:0] high_cyc;
  logic rlx;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic hbp_pkg::hbp_kind_e kind_of(input logic w, input logic [2:0] a);
    if (a == hbp_pkg::REG_DATA) begin
      return hbp_pkg::KIND_DATA;
    end else if (w && a == hbp_pkg::REG_PTR_LOW) begin
      return hbp_pkg::KIND_PTR_LOW_WR;
    end
    return hbp_pkg::KIND_OTHER;
  endfunction

  // cycles needed since the last trailing edge before this access
  function automatic logic [7:0] trail_need(input hbp_pkg::hbp_kind_e prev, input logic w,
                                            input logic [2:0] a, input logic [7:0] s);
    logic ptr_rd;
    logic ptr_lo_wr;
    ptr_rd = !w && (a == hbp_pkg::REG_PTR_LOW || a == hbp_pkg::REG_PTR_HIGH);
    ptr_lo_wr = w && a == hbp_pkg::REG_PTR_LOW;
    if (prev == hbp_pkg::KIND_PTR_LOW_WR) begin
      return 8'(hbp_pkg::PTR_LOW_WR_TARB * s);
    end else if (prev == hbp_pkg::KIND_DATA && ptr_rd) begin
      return 8'(hbp_pkg::DATA_TO_PTR_TARB * s);
    end else if (prev == hbp_pkg::KIND_DATA && ptr_lo_wr) begin
      return 8'(hbp_pkg::DATA_TO_PTR_TARB * s);
    end
    return 8'h00;
  endfunction

  // cycles needed since the last leading edge
  function automatic logic [7:0] lead_need(input logic w, input logic rlx, input logic [7:0] s);
    logic [7:0] base;
    base = 8'(hbp_pkg::LEAD_TARB * s);
    if (!w && rlx) begin
      base = base + 8'(hbp_pkg::RELAX_CYCLE_CYC);
    end
    return base;
  endfunction

  // ------------------------------------------------------------
  // pacing scale and pin widths
  // ------------------------------------------------------------
  always_comb begin
    // a low strap pin forces relaxed reads just as the bit does
    rlx = relaxed_timing || !bus_timing_high;
    // one arbitration period is one or two clocks, optionally doubled
    scale = slow_arbitration ? 8'h02 : 8'h01;
    if (double_cycle) begin
      scale = scale << 1;
    end
    if (r.write) begin
      low_cyc = 8'(hbp_pkg::WR_LOW_CYC);
    end else if (rlx) begin
      low_cyc = 8'(hbp_pkg::RD_LOW_RELAX_CYC);
    end else begin
      low_cyc = 8'(hbp_pkg::RD_LOW_CYC);
    end
    high_cyc = rlx ? 8'(hbp_pkg::HIGH_RELAX_CYC) : 8'(hbp_pkg::HIGH_CYC);
  end

  // ready only when idle and every gap that this access needs has passed
  assign req_ready = (r.state == H_IDLE) &&
                     (r.lead_cnt >= lead_need(req_write, rlx, scale)) &&
                     (r.trail_cnt >= trail_need(r.prev_kind, req_write, req_addr, scale));

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.rsp_valid = 1'b0;
    n.bt = bus_timing_high;
    // returned data is asynchronous to us: three flops and agreement
    n.d1 = bus.data;
    n.d2 = r.d1;
    n.d3 = r.d2;
    n.dfilt = (r.d2 & r.d3) | (r.dfilt & (r.d2 | r.d3));
    if (r.lead_cnt != hbp_pkg::CNT_SAT) begin
      n.lead_cnt = r.lead_cnt + 8'h01;
    end
    if (r.trail_cnt != hbp_pkg::CNT_SAT) begin
      n.trail_cnt = r.trail_cnt + 8'h01;
    end
    if (r.cnt != 8'h00) begin
      n.cnt = r.cnt - 8'h01;
    end
    case (r.state)
      H_IDLE: begin
        if (req_valid && req_ready) begin
          n.write = req_write;
          n.addr = req_addr;
          n.wdata = req_wdata;
          n.cs_n = 1'b0;
          n.dir = !req_write;
          n.d_oe_n = !req_write;
          if (mux_bus) begin
            n.ale = 1'b1;
            n.cnt = 8'(hbp_pkg::ALE_HIGH_CYC - 1);
            n.state = H_ALE;
          end else begin
            n.cnt = 8'(hbp_pkg::ADDR_SETUP_CYC - 1);
            n.state = H_SETUP;
          end
        end
      end
      H_ALE: begin
        if (r.cnt == 8'h00) begin
          n.ale = 1'b0;
          n.cnt = 8'(hbp_pkg::ALE_TO_STB_CYC - 1);
          n.state = H_ALE_LOW;
        end
      end
      H_ALE_LOW, H_SETUP: begin
        if (r.cnt == 8'h00) begin
          n.lead_cnt = 8'h00;
          n.cnt = low_cyc - 8'h01;
          n.state = H_STROBE;
          if (strobe_style) begin
            n.ds_n = 1'b0;
          end else if (r.write) begin
            n.wr_n = 1'b0;
          end else begin
            n.rd_n = 1'b0;
          end
        end
      end
      H_STROBE: begin
        if (r.cnt == 8'h00) begin
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          n.ds_n = 1'b1;
          n.trail_cnt = 8'h00;
          n.prev_kind = kind_of(r.write, r.addr);
          n.rdata = r.dfilt;
          n.rsp_valid = !r.write;
          n.cnt = high_cyc - 8'h01;
          n.state = H_HOLD;
        end
      end
      H_HOLD: begin
        // direction and select hold past the strobe release
        if (r.cnt == 8'h00) begin
          n.cs_n = 1'b1;
          n.d_oe_n = 1'b1;
          n.state = H_IDLE;
        end
      end
      default: n.state = H_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.state <= H_IDLE;
      r.prev_kind <= hbp_pkg::KIND_OTHER;
      r.lead_cnt <= hbp_pkg::CNT_SAT;
      r.trail_cnt <= hbp_pkg::CNT_SAT;
      r.cs_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.ds_n <= 1'b1;
      r.d_oe_n <= 1'b1;
      r.bt <= 1'b1;
      r.d1 <= 8'hff;
      r.d2 <= 8'hff;
      r.d3 <= 8'hff;
      r.dfilt <= 8'hff;
    end else begin
      r <= n;
    end
  end

  // pins and answer straight from flops
  assign bus.ale = r.ale;
  assign bus.chip_select_n = r.cs_n;
  assign bus.read_strobe_n = r.rd_n;
  assign bus.write_strobe_n = r.wr_n;
  assign bus.data_strobe_n = r.ds_n;
  assign bus.direction = r.dir;
  assign bus.bus_timing_pin = r.bt;
  assign bus.addr = r.addr;
  assign bus.host_d_out = r.wdata;
  assign bus.host_d_oe_n = r.d_oe_n;
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rdata;

endmodule
`default_nettype wire

// ---- common/hbp_pkg.sv ----
// constants and types shared by both ends of the paced host bus
package hbp_pkg;

  // ------------------------------------------------------------
  // clock and pacing
  // ------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int LEAD_TARB = 4;
  localparam int DATA_TO_PTR_TARB = 5;
  localparam int PTR_LOW_WR_TARB = 4;

  // least pin times, ns
  localparam int ALE_HIGH_NS = 20;
  localparam int ALE_TO_STB_NS = 15;
  localparam int ADDR_SETUP_NS = 15;
  localparam int RD_LOW_NS = 60;
  localparam int RD_LOW_RELAX_NS = 100;
  localparam int WR_LOW_RELAX_NS = 65;
  localparam int HIGH_NS = 20;
  localparam int HIGH_RELAX_NS = 30;
  localparam int RELAX_CYCLE_NS = 30;

  // least time rounds up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ALE_HIGH_CYC = ns_to_cyc(ALE_HIGH_NS);
  localparam int ALE_TO_STB_CYC = ns_to_cyc(ALE_TO_STB_NS);
  localparam int ADDR_SETUP_CYC = ns_to_cyc(ADDR_SETUP_NS);
  localparam int RD_LOW_CYC = ns_to_cyc(RD_LOW_NS);
  localparam int RD_LOW_RELAX_CYC = ns_to_cyc(RD_LOW_RELAX_NS);
  localparam int WR_LOW_CYC = ns_to_cyc(WR_LOW_RELAX_NS);
  localparam int HIGH_CYC = ns_to_cyc(HIGH_NS);
  localparam int HIGH_RELAX_CYC = ns_to_cyc(HIGH_RELAX_NS);
  localparam int RELAX_CYCLE_CYC = ns_to_cyc(RELAX_CYCLE_NS);

  // ------------------------------------------------------------
  // register offsets and widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_PTR_LOW = 3'h1;
  localparam logic [2:0] REG_PTR_HIGH = 3'h2;
  localparam logic [7:0] CNT_SAT = 8'hff;

  typedef logic [7:0] hbp_cnt_t;
  typedef enum logic [1:0] {KIND_OTHER, KIND_DATA, KIND_PTR_LOW_WR} hbp_kind_e;

  // pins as the device samples them
  typedef struct packed {
    logic bus_timing_pin;
    logic ale;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic data_strobe_n;
    logic direction;
    logic [2:0] addr;
    logic [7:0] data;
  } hbp_pins_s;

  localparam int PINS_W = $bits(hbp_pins_s);
  // latch strobe idles low and data idles at the pull-up, so no false edge follows reset
  localparam logic [17:0] PINS_IDLE = 18'h2f8ff;

endpackage

// ---- common/hbp_bus_if.sv ----
// parallel bus wires between the host and the device
`timescale 1ns/1ps
`default_nettype none
interface hbp_bus_if;
  logic ale;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic data_strobe_n;
  logic direction;
  logic bus_timing_pin;
  logic [2:0] addr;
  logic [7:0] host_d_out;
  logic host_d_oe_n;
  logic [7:0] dev_d_out;
  logic dev_d_oe_n;
  logic [7:0] data;

  // resolved data lines, pulled up when nobody drives
  assign data = !host_d_oe_n ? host_d_out : (!dev_d_oe_n ? dev_d_out : 8'hff);

  modport host (output ale, chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n,
                direction, bus_timing_pin, addr, host_d_out, host_d_oe_n, input data);
  modport device (input ale, chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n,
                  direction, bus_timing_pin, addr, data, output dev_d_out, dev_d_oe_n);
endinterface
`default_nettype wire

// ---- rtl/hbp_device.sv ----
// device end: synchronised strobes, pointer registers and buffer ram
`timescale 1ns/1ps
`default_nettype none
module hbp_device #(
  parameter int PTR_W = 11
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus pins
  hbp_bus_if.device bus,
  // configuration
  input wire logic slow_arbitration,
  input wire logic relaxed_timing_bit,
  input wire logic mux_bus,
  input wire logic strobe_style,
  // status
  output logic relaxed_read,
  output logic pacing_violation,
  output logic [PTR_W-1:0] pointer
);

  typedef struct packed {
    logic [hbp_pkg::PINS_W-1:0] s1;
    logic [hbp_pkg::PINS_W-1:0] s2;
    logic [hbp_pkg::PINS_W-1:0] s3;
    logic [hbp_pkg::PINS_W-1:0] filt;
    logic [hbp_pkg::PINS_W-1:0] pfilt;
    logic arb_phase;
    logic [2:0] lat_addr;
    logic lat_cs_n;
    logic rd_act;
    logic wr_act;
    logic [2:0] cur_addr;
    hbp_pkg::hbp_cnt_t lead_cnt;
    logic dly;
    logic drive;
    logic [7:0] rdata;
    logic [PTR_W-1:0] ptr;
    logic violation;
  } hbp_dev_s;

  hbp_dev_s r, n;
  hbp_pkg::hbp_pins_s f, pf;
  logic [7:0] mem [2**PTR_W];
  logic tick, relaxed, rd_now, wr_now, sel_now, start, mem_we;
  logic [2:0] addr_now;
  logic [7:0] rd_mux;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    f = hbp_pkg::hbp_pins_s'(r.filt);
    pf = hbp_pkg::hbp_pins_s'(r.pfilt);
    mem_we = 1'b0;
    // pin samples pass three flops; a bit moves once stages two and three agree
    n.s1 = {bus.bus_timing_pin, bus.ale, bus.chip_select_n, bus.read_strobe_n,
            bus.write_strobe_n, bus.data_strobe_n, bus.direction, bus.addr, bus.data};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = (r.s2 & r.s3) | (r.filt & (r.s2 | r.s3));
    n.pfilt = r.filt;
    // arbitration tick every clock, or every other clock when slowed
    tick = !slow_arbitration || r.arb_phase;
    n.arb_phase = slow_arbitration ? !r.arb_phase : 1'b0;
    if (tick && r.lead_cnt != hbp_pkg::CNT_SAT) begin
      n.lead_cnt = r.lead_cnt + 8'h01;
    end
    relaxed = relaxed_timing_bit || !f.bus_timing_pin;
    rd_now = strobe_style ? (!f.data_strobe_n && f.direction) : !f.read_strobe_n;
    wr_now = strobe_style ? (!f.data_strobe_n && !f.direction) : !f.write_strobe_n;
    sel_now = mux_bus ? !r.lat_cs_n : !f.chip_select_n;
    addr_now = mux_bus ? r.lat_addr : f.addr;
    // latch address and select on the falling latch strobe
    if (pf.ale && !f.ale) begin
      n.lat_addr = f.addr;
      n.lat_cs_n = f.chip_select_n;
    end
    case (r.cur_addr)
      hbp_pkg::REG_DATA: rd_mux = mem[r.ptr];
      hbp_pkg::REG_PTR_LOW: rd_mux = r.ptr[7:0];
      hbp_pkg::REG_PTR_HIGH: rd_mux = 8'({r.ptr[PTR_W-1:8]});
      default: rd_mux = 8'h00;
    endcase
    start = !r.rd_act && !r.wr_act && (rd_now || wr_now) && sel_now;
    n.violation = 1'b0;
    if (start) begin
      n.cur_addr = addr_now;
      // the tick of this very edge counts, so exactly four periods is legal
      n.violation = ({1'b0, r.lead_cnt} + 9'(tick)) < 9'(hbp_pkg::LEAD_TARB);
      n.lead_cnt = 8'h00;
      n.dly = rd_now && relaxed;
    end
    n.rd_act = rd_now && (r.rd_act || start);
    n.wr_act = wr_now && (r.wr_act || start);
    // relaxed reads present data one arbitration period later
    if (r.rd_act && tick) begin
      n.dly = 1'b0;
    end
    if (r.rd_act && !r.drive) begin
      n.rdata = rd_mux;
    end
    n.drive = r.rd_act && n.rd_act && !r.dly;
    // read of data register advances the pointer at the trailing edge
    if (r.rd_act && !rd_now && r.cur_addr == hbp_pkg::REG_DATA) begin
      n.ptr = r.ptr + PTR_W'(1);
    end
    // write takes effect at the trailing edge, same timing in both modes
    if (r.wr_act && !wr_now) begin
      case (r.cur_addr)
        hbp_pkg::REG_DATA: begin
          mem_we = 1'b1;
          n.ptr = r.ptr + PTR_W'(1);
        end
        hbp_pkg::REG_PTR_LOW: n.ptr[7:0] = pf.data;
        hbp_pkg::REG_PTR_HIGH: n.ptr[PTR_W-1:8] = pf.data[PTR_W-9:0];
        default: n.ptr = r.ptr;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.s1 <= hbp_pkg::PINS_IDLE;
      r.s2 <= hbp_pkg::PINS_IDLE;
      r.s3 <= hbp_pkg::PINS_IDLE;
      r.filt <= hbp_pkg::PINS_IDLE;
      r.pfilt <= hbp_pkg::PINS_IDLE;
      r.lat_cs_n <= 1'b1;
      r.lead_cnt <= hbp_pkg::CNT_SAT;
    end else begin
      r <= n;
    end
  end

  // buffer ram, no reset on contents
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[r.ptr] <= pf.data;
    end
  end

  // outputs
  assign bus.dev_d_out = r.rdata;
  assign bus.dev_d_oe_n = !r.drive;
  assign relaxed_read = relaxed;
  assign pacing_violation = r.violation;
  assign pointer = r.ptr;

endmodule
`default_nettype wire

// ---- testbench/hbp_checker.sv ----
// pacing and framing checks on the bus between host and device
`timescale 1ns/1ps
`default_nettype none
module hbp_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration and status
  input wire logic mux_bus,
  input wire logic slow_arbitration,
  input wire logic pacing_violation,
  // bus wires
  input wire logic ale,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_strobe_n,
  input wire logic direction,
  input wire logic [2:0] addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // strobe edges and gap counters
  // ------------------------------------------------------------
  logic stb_q;
  logic wr_q;
  logic l_data;
  logic l_plw;
  logic [2:0] a_l;
  logic [2:0] a_q;
  int lead;
  int trail;
  int sc;
  wire logic stb_n = read_strobe_n & write_strobe_n & data_strobe_n;
  wire logic wr = !write_strobe_n | (!data_strobe_n & !direction);
  wire logic fall = stb_q & !stb_n;
  wire logic rise = !stb_q & stb_n;
  wire logic [2:0] cur = mux_bus ? a_l : addr;
  assign sc = slow_arbitration ? 2 : 1;
  // counters saturate so a long idle never wraps into a false gap
  always_ff @(posedge clock) begin
    if (reset) begin
      stb_q <= 1'b1;
      lead <= 999;
      trail <= 999;
      l_data <= 1'b0;
      l_plw <= 1'b0;
    end else begin
      stb_q <= stb_n;
      lead <= fall ? 1 : (lead < 999 ? lead + 1 : lead);
      trail <= rise ? 1 : (trail < 999 ? trail + 1 : trail);
      if (ale) a_l <= addr;
      if (fall) begin
        a_q <= cur;
        wr_q <= wr;
      end
      if (rise) begin
        l_data <= a_q == hbp_pkg::REG_DATA;
        l_plw <= (a_q == hbp_pkg::REG_PTR_LOW) && wr_q;
      end
    end
  end
  // gaps measured in clocks, scaled by the arbitration rate
  a_lead_gap: assert property (fall |-> lead >= hbp_pkg::LEAD_TARB * sc)
    else $error("strobe leading edges too close");
  a_lead_slow: assert property (fall && slow_arbitration |-> lead >= 2 * hbp_pkg::LEAD_TARB)
    else $error("slow rate lead gap too short");
  a_data_ptr_rd: assert property (fall && l_data && !wr &&
    (cur == hbp_pkg::REG_PTR_LOW || cur == hbp_pkg::REG_PTR_HIGH)
    |-> trail >= hbp_pkg::DATA_TO_PTR_TARB * sc)
    else $error("pointer read too soon after data access");
  a_ptr_low_after: assert property (fall && l_plw |-> trail >= hbp_pkg::PTR_LOW_WR_TARB * sc)
    else $error("cycle too soon after pointer low write");
  a_data_ptr_wr: assert property (fall && l_data && wr && cur == hbp_pkg::REG_PTR_LOW
    |-> trail >= hbp_pkg::DATA_TO_PTR_TARB * sc)
    else $error("pointer low write too soon after data access");
  a_dir_stable: assert property (!data_strobe_n || !$past(data_strobe_n) |-> $stable(direction))
    else $error("direction moved around data strobe");
  a_latch_select: assert property ($fell(ale) |-> !chip_select_n && stb_n ##[1:12] !stb_n)
    else $error("select or strobe wrong around latch fall");
  a_no_violation: assert property (!pacing_violation)
    else $error("device flagged a pacing violation");
  c_ptr_after_data: cover property (fall && l_data && cur == hbp_pkg::REG_PTR_LOW);
  c_slow_strobe: cover property (fall && slow_arbitration);
  c_latch: cover property ($fell(ale));
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// top testbench: host and device joined, plus a strobe driver that breaks pacing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // signals, instances and clock
  // ------------------------------------------------------------
  logic clock, reset, slow, mux, style, rbit, dbl, btm, slow2, seen;
  logic req_valid, req_write, req_ready, rsp_valid, viol, viol2, relaxed;
  logic [2:0] req_addr;
  logic [7:0] req_wdata, rsp_rdata, d;
  logic [10:0] pointer;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  hbp_bus_if bus1();
  hbp_bus_if bus2();
  hbp_host u_hbp_host (.clock(clock), .reset(reset), .bus(bus1), .slow_arbitration(slow),
    .relaxed_timing(rbit), .mux_bus(mux), .strobe_style(style), .double_cycle(dbl),
    .bus_timing_high(btm), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hbp_device u_hbp_device (.clock(clock), .reset(reset), .bus(bus1), .slow_arbitration(slow),
    .relaxed_timing_bit(rbit), .mux_bus(mux), .strobe_style(style), .relaxed_read(relaxed),
    .pacing_violation(viol), .pointer(pointer));
  hbp_device u_hbp_device_b (.clock(clock), .reset(reset), .bus(bus2), .slow_arbitration(slow2),
    .relaxed_timing_bit(1'b0), .mux_bus(1'b0), .strobe_style(1'b0), .relaxed_read(),
    .pacing_violation(viol2), .pointer());
  hbp_checker u_hbp_checker (.clock(clock), .reset(reset), .mux_bus(mux),
    .slow_arbitration(slow), .pacing_violation(viol), .ale(bus1.ale),
    .chip_select_n(bus1.chip_select_n), .read_strobe_n(bus1.read_strobe_n),
    .write_strobe_n(bus1.write_strobe_n), .data_strobe_n(bus1.data_strobe_n),
    .direction(bus1.direction), .addr(bus1.addr));
  // free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // hang guard, well above the length of all tests
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end
  // comparisons
  task automatic chk_val(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask
  // request held until the host takes it; a fresh edge each time avoids double drives
  task automatic req(input logic w, input logic [2:0] a, input logic [7:0] v);
    @(posedge clock) #1;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = v;
    while (req_ready !== 1'b1) @(posedge clock) #1;
    @(posedge clock) #1;
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    req(1'b0, a, 8'h00);
    while (rsp_valid !== 1'b1) @(posedge clock) #1;
    v = rsp_rdata;
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, btm} = 2'h3;
    {req_valid, req_write, slow, mux, style, rbit, dbl, slow2} = 8'h00;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    {bus2.ale, bus2.chip_select_n, bus2.read_strobe_n, bus2.write_strobe_n} = 4'h7;
    {bus2.data_strobe_n, bus2.direction, bus2.bus_timing_pin, bus2.host_d_oe_n} = 4'hf;
    bus2.addr = 3'h3;
    bus2.host_d_out = 8'h00;
    repeat (5) @(posedge clock);
    #1 reset = 1'b0;
    repeat (2) @(posedge clock);
    // every bus style, rate and timing case, with the awkward access orders
    for (int i = 0; i < 16; i++) begin
      logic [7:0] iv;
      iv = 8'(i);
      repeat (40) @(posedge clock);
      #1 {rbit, btm, slow, style, mux} = {iv[3] & iv[0], !(iv[3] & !iv[0]), iv[2:0]};
      dbl = iv[0] ^ iv[1];
      req(1'b1, 3'h2, iv);
      req(1'b1, 3'h1, 8'h10 + iv);
      req(1'b1, 3'h0, {4'ha, iv[3:0]});
      req(1'b1, 3'h0, {4'h5, iv[3:0]});
      req(1'b1, 3'h1, 8'h10 + iv);
      rd(3'h0, d);
      chk_val("data byte", {3'h0, 4'ha, iv[3:0]}, {3'h0, d});
      req(1'b1, 3'h1, 8'h10 + iv);
      rd(3'h0, d);
      chk_val("data byte", {3'h0, 4'ha, iv[3:0]}, {3'h0, d});
      rd(3'h1, d);
      chk_val("pointer low", {3'h0, 8'h11 + iv}, {3'h0, d});
      req(1'b1, 3'h0, 8'h3c);
      rd(3'h2, d);
      chk_val("pointer high", {8'h00, iv[2:0]}, {3'h0, d});
      rd(3'h3, d);
      chk_val("unused read", 11'h000, {3'h0, d});
      chk_val("pointer", {iv[2:0], 8'h12 + iv}, pointer);
      chk_flag("relaxed read", iv[3], relaxed);
      $display("mode test %0d done", i);
    end
    // strobe pairs six clocks apart: too close only when slow; four is the fast limit
    for (int s = 0; s < 3; s++) begin
      int g;
      int h;
      g = (s == 2) ? 4 : 6;
      h = g / 2;
      slow2 = (s == 1);
      seen = 1'b0;
      for (int k = 0; k < 40; k++) begin
        @(posedge clock) #1;
        bus2.write_strobe_n = !((k >= 2 && k < 2 + h) || (k >= 2 + g && k < 2 + g + h));
        bus2.chip_select_n = !(k >= 1 && k < 3 + g + h);
        seen = seen | viol2;
      end
      chk_flag("pacing violation", s == 1, seen);
      $display("strobe pair test %0d done", s);
    end
    conclude();
  end
endmodule
`default_nettype wire
